/* File: rtl/attr_cfg_pkg.sv */
// Package: constants, states and carriers for the card attribute space decoder
package attr_cfg_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int ADDR_LOW_W = 10;
   // Register offsets in attribute space
   localparam logic [15:0] OPTION_OFFSET = 16'h8000;
   localparam logic [15:0] STATUS_OFFSET = 16'h8002;
   localparam int REGION_BIT = 15;
   // Option register fields
   localparam int OPT_SOFT_RESET = 7;
   localparam int OPT_LEVEL_IRQ = 6;
   localparam int OPT_ATTR_WRITE = 2;
   localparam int OPT_FUNC_ENABLE = 0;
   localparam logic [7:0] OPTION_RESET = 8'h40;
   localparam logic [7:0] OPTION_WMASK = 8'h85;
   // Status register fields
   localparam int STS_NARROW = 5;
   localparam int STS_POWER_DOWN = 2;
   localparam int STS_INTR = 1;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] STATUS_WMASK = 8'h24;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_EXT = 2'b01,
      ST_REG = 2'b10,
      ST_WAIT_END = 2'b11
   } access_e;

   typedef struct packed
   {
      logic reg_n;
      logic ce1_n;
      logic we_n;
      logic oe_n;
   } host_strobe_s;

   typedef struct packed
   {
      logic func_enabled;
      logic power_down;
      logic narrow_host;
      logic attr_write_ok;
   } func_ctrl_s;
endpackage

/* File: rtl/attr_cfg_space.sv */
// Card attribute space decoder with the two function configuration registers
`timescale 1ns/10ps
// ************************************************************
// ************************************************************
module attr_cfg_space
   import attr_cfg_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Host card bus
   input wire logic [attr_cfg_pkg::ADDR_W-1:0] host_addr,
   input wire attr_cfg_pkg::host_strobe_s host_strb,
   input wire logic [attr_cfg_pkg::DATA_W-1:0] host_wdata,
   output logic [attr_cfg_pkg::DATA_W-1:0] host_rdata,
   output logic host_rdata_oe,
   // External attribute memory
   output logic ext_mem_select_n,
   output logic ext_mem_write_strobe_n,
   output logic [attr_cfg_pkg::ADDR_LOW_W-1:0] ext_mem_addr,
   // Function side
   input wire logic func_irq_req,
   input wire logic func_io_access,
   input wire logic wake_on_packet_cfg,
   input wire logic wide_bus_strap_n,
   input wire logic wide_mode_setting,
   output logic func_soft_reset,
   output logic func_power_down,
   output logic func_io_enable,
   output logic func_wake_enable,
   output logic func_wide_bus,
   output logic inpack_n,
   output logic irq_request_out,
   output logic irq_ready_pin_n,
   output logic wide_io_indicator,
   output logic wide_io_indicator_oe
);
   import attr_cfg_pkg::*;

   // ************************************************************
   // Decode
   // ************************************************************
   logic [7:0] option_q;
   logic [7:0] status_q;
   logic intr_q;
   access_e state_q;
   logic cycle_active;
   logic is_reg_region;
   logic odd_byte;
   logic rd_strobe;
   logic wr_strobe;
   func_ctrl_s ctrl;

   // Register select from the limited decode
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
      reg_hit = (a[REGION_BIT] == off[REGION_BIT]) && (a[ADDR_LOW_W-1:0] == off[ADDR_LOW_W-1:0]);
   endfunction

   assign cycle_active = !host_strb.reg_n && !host_strb.ce1_n;
   assign rd_strobe = cycle_active && !host_strb.oe_n;
   assign wr_strobe = cycle_active && !host_strb.we_n;
   assign is_reg_region = host_addr[REGION_BIT];
   assign odd_byte = host_addr[0];

   assign ctrl.func_enabled = option_q[OPT_FUNC_ENABLE];
   assign ctrl.power_down = status_q[STS_POWER_DOWN] || !option_q[OPT_FUNC_ENABLE];
   assign ctrl.narrow_host = status_q[STS_NARROW];
   assign ctrl.attr_write_ok = option_q[OPT_ATTR_WRITE];

   // ************************************************************
   // Access sequencer
   // ************************************************************
   // One register write per strobe: wait for strobes to drop before rearming
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (rd_strobe || wr_strobe)
               begin
                  state_q <= is_reg_region ? ST_REG : ST_EXT;
               end
            end
            ST_EXT, ST_REG:
            begin
               state_q <= ST_WAIT_END;
            end
            ST_WAIT_END:
            begin
               if (!rd_strobe && !wr_strobe)
               begin
                  state_q <= ST_IDLE;
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   logic reg_wr_take;
   assign reg_wr_take = (state_q == ST_IDLE) && wr_strobe && is_reg_region && !odd_byte;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         option_q <= OPTION_RESET;
      end
      else if (reg_wr_take && reg_hit(host_addr, OPTION_OFFSET))
      begin
         option_q <= (host_wdata[7:0] & OPTION_WMASK) | OPTION_RESET;
      end
   end

   // soft reset clears function state except the option register itself
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         status_q <= STATUS_RESET;
      end
      else if (option_q[OPT_SOFT_RESET])
      begin
         status_q <= STATUS_RESET;
      end
      else if (reg_wr_take && reg_hit(host_addr, STATUS_OFFSET))
      begin
         status_q <= host_wdata[7:0] & STATUS_WMASK;
      end
   end

   // pending bit tracks the function request while the function is enabled and out of soft reset
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         intr_q <= 1'b0;
      end
      else
      begin
         intr_q <= func_irq_req && ctrl.func_enabled && !option_q[OPT_SOFT_RESET];
      end
   end

   // ************************************************************
   // Host read data and external memory strobes
   // ************************************************************
   logic [7:0] reg_rd;
   always_comb
   begin
      reg_rd = 8'h00;
      if (reg_hit(host_addr, OPTION_OFFSET))
      begin
         reg_rd = option_q | OPTION_RESET;
      end
      else if (reg_hit(host_addr, STATUS_OFFSET))
      begin
         reg_rd = status_q;
         reg_rd[STS_INTR] = intr_q;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         host_rdata <= 16'h0000;
         host_rdata_oe <= 1'b0;
         ext_mem_select_n <= 1'b1;
         ext_mem_write_strobe_n <= 1'b1;
         ext_mem_addr <= '0;
      end
      else
      begin
         // odd attribute byte reads zero, high byte don't care
         host_rdata <= {8'h00, (odd_byte ? 8'h00 : reg_rd)};
         // float data bus for the external memory
         host_rdata_oe <= rd_strobe && (is_reg_region || odd_byte);
         // select external memory in lower region
         ext_mem_select_n <= !(cycle_active && !is_reg_region && !odd_byte && (rd_strobe || wr_strobe));
         // writes gated by the write-allow bit
         ext_mem_write_strobe_n <= !(wr_strobe && !is_reg_region && !odd_byte && ctrl.attr_write_ok);
         ext_mem_addr <= {host_addr[ADDR_LOW_W-1:1], 1'b0};
      end
   end

   // ************************************************************
   // Function control outputs
   // ************************************************************
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         func_soft_reset <= 1'b0;
         func_power_down <= 1'b1;
         func_io_enable <= 1'b0;
         func_wake_enable <= 1'b0;
         func_wide_bus <= 1'b0;
         inpack_n <= 1'b1;
         irq_request_out <= 1'b0;
         irq_ready_pin_n <= 1'b1;
         wide_io_indicator <= 1'b0;
         wide_io_indicator_oe <= 1'b0;
      end
      else
      begin
         func_soft_reset <= option_q[OPT_SOFT_RESET];
         func_power_down <= ctrl.power_down;
         func_io_enable <= ctrl.func_enabled && !ctrl.power_down;
         func_wake_enable <= wake_on_packet_cfg && ctrl.func_enabled;
         // narrow host overrides strap and wide setting
         func_wide_bus <= !ctrl.narrow_host && !wide_bus_strap_n && wide_mode_setting;
         wide_io_indicator <= !wide_bus_strap_n && wide_mode_setting;
         wide_io_indicator_oe <= !ctrl.narrow_host && ctrl.func_enabled;
         inpack_n <= !(func_io_access && ctrl.func_enabled);
         irq_request_out <= intr_q;
         // pin held low during soft reset
         irq_ready_pin_n <= !option_q[OPT_SOFT_RESET];
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_odd_read_zero: assert property (@(posedge core_clk) disable iff (rst)
      rd_strobe && odd_byte |=> host_rdata == 16'h0000)
      else $error("odd read not zero");
   a_level_bit_one: assert property (@(posedge core_clk) disable iff (rst)
      option_q[OPT_LEVEL_IRQ])
      else $error("level bit cleared");
   a_ext_wr_gate: assert property (@(posedge core_clk) disable iff (rst)
      !ext_mem_write_strobe_n |-> $past(ctrl.attr_write_ok))
      else $error("ext write without allow");
   a_odd_no_write: assert property (@(posedge core_clk) disable iff (rst)
      wr_strobe && odd_byte && is_reg_region |=> $stable(option_q[OPT_FUNC_ENABLE]) && $stable(status_q))
      else $error("odd write took effect");
   a_soft_rst_pin: assert property (@(posedge core_clk) disable iff (rst)
      option_q[OPT_SOFT_RESET] |=> !irq_ready_pin_n && status_q == STATUS_RESET)
      else $error("soft reset not applied");
   a_disabled_quiet: assert property (@(posedge core_clk) disable iff (rst)
      !ctrl.func_enabled [*2] |=> !irq_request_out && inpack_n)
      else $error("disabled function active");
   a_power_down: assert property (@(posedge core_clk) disable iff (rst)
      ctrl.power_down |=> func_power_down && !func_io_enable)
      else $error("power down missed");
   a_narrow_float: assert property (@(posedge core_clk) disable iff (rst)
      ctrl.narrow_host |=> !wide_io_indicator_oe && !func_wide_bus)
      else $error("narrow host not forced");
   a_irq_follow: assert property (@(posedge core_clk) disable iff (rst)
      intr_q |=> irq_request_out)
      else $error("irq not raised");
   a_wake_gate: assert property (@(posedge core_clk) disable iff (rst)
      !ctrl.func_enabled |=> !func_wake_enable)
      else $error("wake while disabled");

   // ************************************************************
   // Checks on decode paths and function outputs
   // ************************************************************
   a_idle_no_select: assert property (@(posedge core_clk) disable iff (rst)
      !cycle_active |=> ext_mem_select_n && ext_mem_write_strobe_n)
      else $error("memory selected without card cycle");
   a_ext_read_float: assert property (@(posedge core_clk) disable iff (rst)
      rd_strobe && !is_reg_region && !odd_byte |=> !ext_mem_select_n && !host_rdata_oe)
      else $error("external read not handed to memory");
   a_odd_no_select: assert property (@(posedge core_clk) disable iff (rst)
      odd_byte |=> ext_mem_select_n && ext_mem_write_strobe_n)
      else $error("odd byte reached memory");
   a_ext_addr_even: assert property (@(posedge core_clk) disable iff (rst)
      !ext_mem_select_n |-> ext_mem_addr == {$past(host_addr[ADDR_LOW_W-1:1]), 1'b0})
      else $error("memory address not even copy");
   a_reg_no_select: assert property (@(posedge core_clk) disable iff (rst)
      is_reg_region |=> ext_mem_select_n && ext_mem_write_strobe_n)
      else $error("register region reached memory");
   a_odd_reg_read: assert property (@(posedge core_clk) disable iff (rst)
      rd_strobe && odd_byte && is_reg_region |=> host_rdata == 16'h0000 && host_rdata_oe)
      else $error("odd register read not zero");
   a_level_read_one: assert property (@(posedge core_clk) disable iff (rst)
      rd_strobe && !odd_byte && reg_hit(host_addr, OPTION_OFFSET) |=> host_rdata[OPT_LEVEL_IRQ])
      else $error("level bit read as zero");
   a_even_write_lands: assert property (@(posedge core_clk) disable iff (rst)
      reg_wr_take && reg_hit(host_addr, STATUS_OFFSET) && !option_q[OPT_SOFT_RESET]
      |=> status_q == ($past(host_wdata[7:0]) & STATUS_WMASK))
      else $error("even status write lost");
   a_soft_rst_out: assert property (@(posedge core_clk) disable iff (rst)
      option_q[OPT_SOFT_RESET] |=> func_soft_reset)
      else $error("soft reset not passed on");
   a_pin_raised: assert property (@(posedge core_clk) disable iff (rst)
      !option_q[OPT_SOFT_RESET] |=> irq_ready_pin_n)
      else $error("pin not raised after soft reset");
   a_intr_gated: assert property (@(posedge core_clk) disable iff (rst)
      intr_q |-> $past(ctrl.func_enabled))
      else $error("pending while disabled");
   a_inpack_gated: assert property (@(posedge core_clk) disable iff (rst)
      !inpack_n |-> $past(ctrl.func_enabled) && $past(func_io_access))
      else $error("inpack without enabled access");
   a_io_disabled: assert property (@(posedge core_clk) disable iff (rst)
      !ctrl.func_enabled |=> !func_io_enable && func_power_down)
      else $error("disabled function reachable");
   a_wide_blocked: assert property (@(posedge core_clk) disable iff (rst)
      func_wide_bus |-> !$past(ctrl.narrow_host))
      else $error("wide bus under narrow host");
   a_ext_wr_pass: assert property (@(posedge core_clk) disable iff (rst)
      wr_strobe && !is_reg_region && !odd_byte && ctrl.attr_write_ok
      |=> !ext_mem_write_strobe_n && !ext_mem_select_n)
      else $error("allowed memory write dropped");
endmodule

/* File: dv/host_socket_model.sv */
// Host socket controller model driving card attribute cycles
`timescale 1ns/10ps
module host_socket_model
   import attr_cfg_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Answer from the card
   input wire logic [15:0] host_rdata,
   input wire logic host_rdata_oe,
   input wire logic ext_mem_select_n,
   input wire logic ext_mem_write_strobe_n,
   input wire logic [9:0] ext_mem_addr,
   // Requests to the card
   output attr_cfg_pkg::host_strobe_s host_strb,
   output logic [15:0] host_addr,
   output logic [15:0] host_wdata
);
   initial
   begin
      host_strb = 4'hf;
      host_addr = 16'h5555;
      host_wdata = 16'haaaa;
   end

   // ************************************************************
   // One attribute cycle
   // ************************************************************
   // Held until the answer edge; released lines show the inverse, not the old value
   task automatic cycle(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [28:0] snap);
      @(posedge core_clk);
      #1;
      host_addr = a;
      host_wdata = d;
      host_strb = {1'b0, 1'b0, ~wr, wr};
      @(posedge core_clk);
      @(posedge core_clk);
      #1;
      snap = {host_rdata_oe, ext_mem_select_n, ext_mem_write_strobe_n, ext_mem_addr, host_rdata};
      host_strb = 4'hf;
      host_addr = ~a;
      host_wdata = ~d;
   endtask

   // Common memory write: register select stays high, so the card must ignore it
   task automatic common_write(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      #1;
      host_addr = a;
      host_wdata = d;
      host_strb = 4'b1001;
      repeat (2) @(posedge core_clk);
      #1;
      host_strb = 4'hf;
      host_addr = ~a;
      host_wdata = ~d;
   endtask
endmodule

/* File: dv/attr_cfg_space_tb_top.sv */
// Testbench for the card attribute space decoder
`timescale 1ns/10ps
module attr_cfg_space_tb_top;
   import attr_cfg_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic irq = 1'b0;
   logic io = 1'b0;
   logic wake = 1'b0;
   logic strap_n = 1'b1;
   logic wmode = 1'b0;
   host_strobe_s strb;
   logic [15:0] addr, wdata, rdata;
   logic rd_oe, sel_n, wstb_n, soft_reset_bit, pdown, io_en, wake_en, wide, inpack_n, irq_out, pin_n, wio, wio_oe;
   logic [9:0] eaddr;
   logic [28:0] s;
   int mismatches = 0;
   int n_compared = 0;

   always #20 core_clk = ~core_clk;

   attr_cfg_space dut (.core_clk(core_clk), .rst(rst), .host_addr(addr), .host_strb(strb), .host_wdata(wdata),
      .host_rdata(rdata), .host_rdata_oe(rd_oe), .ext_mem_select_n(sel_n), .ext_mem_write_strobe_n(wstb_n),
      .ext_mem_addr(eaddr), .func_irq_req(irq), .func_io_access(io), .wake_on_packet_cfg(wake),
      .wide_bus_strap_n(strap_n), .wide_mode_setting(wmode), .func_soft_reset(soft_reset_bit), .func_power_down(pdown),
      .func_io_enable(io_en), .func_wake_enable(wake_en), .func_wide_bus(wide), .inpack_n(inpack_n),
      .irq_request_out(irq_out), .irq_ready_pin_n(pin_n), .wide_io_indicator(wio), .wide_io_indicator_oe(wio_oe));

   host_socket_model host (.core_clk(core_clk), .host_rdata(rdata), .host_rdata_oe(rd_oe),
      .ext_mem_select_n(sel_n), .ext_mem_write_strobe_n(wstb_n), .ext_mem_addr(eaddr), .host_strb(strb),
      .host_addr(addr), .host_wdata(wdata));

   // ************************************************************
   // Compare and access helpers
   // ************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      host.cycle(1'b0, a, 16'h0000, s);
      chk(s[15:0], exp);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      host.cycle(1'b1, a, d, s);
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      rd(16'h8000, 16'h0040);
      rd(16'h8002, 16'h0000);
      chkb(pin_n, 1'b1);
      chkb(pdown, 1'b1);
   endtask
   task automatic t_option();
      wr(16'h8002, 16'h0024);
      rd(16'h8002, 16'h0024);
      wr(16'h8000, 16'h00bf);
      rd(16'h8000, 16'h00c5);
      chkb(pin_n, 1'b0);
      chkb(soft_reset_bit, 1'b1);
      rd(16'h8002, 16'h0000);
      wr(16'h8000, 16'h0005);
      chkb(pin_n, 1'b1);
   endtask
   task automatic t_odd();
      wr(16'h8001, 16'h00ff);
      rd(16'h8000, 16'h0045);
      rd(16'h8001, 16'h0000);
      chkb(s[28], 1'b1);
      rd(16'h8003, 16'h0000);
      host.common_write(16'h8000, 16'h00ff);
      rd(16'h8000, 16'h0045);
   endtask
   task automatic t_ext();
      wr(16'h8000, 16'h0001);
      host.cycle(1'b1, 16'h0412, 16'h00a5, s);
      chk({13'h0000, s[28:26]}, 16'h0001);
      wr(16'h8000, 16'h0005);
      host.cycle(1'b1, 16'h0412, 16'h00a5, s);
      chk({13'h0000, s[28:26]}, 16'h0000);
      host.cycle(1'b0, 16'h0412, 16'h0000, s);
      chk({6'h00, s[25:16]}, 16'h0012);
      chkb(s[28], 1'b0);
      host.cycle(1'b0, 16'h0013, 16'h0000, s);
      chk({6'h00, s[25:16]}, 16'h0012);
      chk(s[15:0], 16'h0000);
      chkb(s[28], 1'b1);
      chkb(s[27], 1'b1);
   endtask
   task automatic t_func();
      irq = 1'b1;
      io = 1'b1;
      wake = 1'b1;
      strap_n = 1'b0;
      wmode = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk({10'h000, irq_out, inpack_n, io_en, wake_en, wide, wio_oe}, 16'h002f);
      chkb(wio, 1'b1);
      rd(16'h8002, 16'h0002);
      wr(16'h8002, 16'h0020);
      chk({14'h0000, wide, wio_oe}, 16'h0000);
      wr(16'h8002, 16'h0004);
      chk({14'h0000, pdown, io_en}, 16'h0002);
      wr(16'h8002, 16'h0000);
      wr(16'h8000, 16'h0004);
      chk({11'h000, irq_out, inpack_n, pdown, io_en, wake_en}, 16'h000c);
   endtask

   // ************************************************************
   // Run control
   // ************************************************************
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_option();
      t_odd();
      t_ext();
      t_func();
      end_sim();
   end

   // Run needs about 100 cycles; allow twenty times that
   initial
   begin
      #80000;
      mismatches++;
      end_sim();
   end
endmodule
